// *** src/system_control_pkg.sv ***
// Purpose: shared constants for the system control coprocessor block
// Assumes: 32-bit coprocessor register transfer instruction words
// Notes: field positions follow the transfer instruction layout
package system_control_pkg;
  // ****************************************
  // Instruction fields
  // ****************************************
  localparam int COND_MSB = 31;
  localparam int OPC1_LSB = 21;
  localparam int DIR_BIT = 20;
  localparam int PRIMARY_LSB = 16;
  localparam int COREREG_LSB = 12;
  localparam int COPNUM_LSB = 8;
  localparam int OPC2_LSB = 5;
  localparam int XFER_BIT = 4;
  localparam int AUX_LSB = 0;
  localparam logic [3:0] GROUP_COPROC = 4'he;
  localparam logic [2:0] GROUP_LOADSTORE = 3'h6;
  localparam logic [3:0] CP_SYSCTL = 4'hf;
  localparam logic [3:0] CP_DEBUG = 4'he;

  // ****************************************
  // Register locations
  // ****************************************
  localparam logic [3:0] REG_IDENT = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_CACHEABLE = 4'h2;
  localparam logic [3:0] REG_WRBUF = 4'h3;
  localparam logic [3:0] REG_PERMIT = 4'h5;
  localparam logic [3:0] REG_REGION = 4'h6;
  localparam logic [3:0] REG_CACHEOP = 4'h7;
  localparam logic [3:0] REG_LOCKDOWN = 4'h9;
  localparam logic [3:0] REG_TEST = 4'hf;
  localparam logic [2:0] OPC2_CACHE_GEOM = 3'h1;
  localparam int REGIONS = 8;

  // ****************************************
  // Reset and fixed values
  // ****************************************
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int CTRL_VECTOR_BIT = 13;
  localparam logic [31:0] CACHE_GEOM_WORD = 32'h0f0f_10f1;

  // Debug channel locations
  localparam logic [3:0] DCC_STATUS = 4'h0;
  localparam logic [3:0] DCC_DATA = 4'h1;

  typedef enum logic [2:0] {
    CLS_NONE = 3'b001,
    CLS_XFER = 3'b010,
    CLS_OTHER = 3'b100
  } instr_class_t;
endpackage

// *** src/cop_instr_decode.sv ***
// Purpose: field extraction of coprocessor instruction words
// Assumes: core has already evaluated the condition field
// Notes: purely combinational
`timescale 1ns/10ps
module cop_instr_decode
  import system_control_pkg::*;
(
  input wire logic [31:0] instr,
  output system_control_pkg::instr_class_t instrClass,
  output logic readDir,
  output logic [3:0] copNum,
  output logic [3:0] primaryIdx,
  output logic [3:0] auxIdx,
  output logic [2:0] opc1,
  output logic [2:0] opc2,
  output logic [3:0] coreReg
);
  import system_control_pkg::*;

  always_comb begin
    if (instr[27:24] == GROUP_COPROC && instr[XFER_BIT]) begin
      instrClass = CLS_XFER;
    end else if (instr[27:24] == GROUP_COPROC || instr[27:25] == GROUP_LOADSTORE) begin
      instrClass = CLS_OTHER;
    end else begin
      instrClass = CLS_NONE;
    end
  end

  assign readDir = instr[DIR_BIT];
  assign copNum = instr[COPNUM_LSB +: 4];
  assign primaryIdx = instr[PRIMARY_LSB +: 4];
  assign auxIdx = instr[AUX_LSB +: 4];
  assign opc1 = instr[OPC1_LSB +: 3];
  assign opc2 = instr[OPC2_LSB +: 3];
  assign coreReg = instr[COREREG_LSB +: 4];
endmodule

// *** src/debug_comms_cop.sv ***
// Purpose: debug communications channel coprocessor
// Assumes: debugger side logic runs on the same clock
// Notes: one word each way, status at location 0
`timescale 1ns/10ps
module debug_comms_cop
  import system_control_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [3:0] idx,
  input wire logic [31:0] wrData,
  output logic [31:0] rdData,
  input wire logic [31:0] dbgRxData,
  input wire logic dbgRxValid,
  output logic dbgRxReady,
  output logic [31:0] dbgTxData,
  output logic dbgTxValid,
  input wire logic dbgTxTaken
);
  import system_control_pkg::*;

  logic rxFull_r;
  logic [31:0] rxData_r;
  logic [31:0] txData_r;
  logic txFull_r;

  assign dbgRxReady = !rxFull_r;
  assign dbgTxData = txData_r;
  assign dbgTxValid = txFull_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      txData_r <= ZERO_WORD;
      rxData_r <= ZERO_WORD;
    end else begin
      if (wrEn && idx == DCC_DATA) begin
        txData_r <= wrData;
      end
      if (dbgRxValid && !rxFull_r) begin
        rxData_r <= dbgRxData;
      end
    end
  end

  // Set beats clear on both flags
  always_ff @(posedge clock) begin
    if (!rstn) begin
      txFull_r <= 1'b0;
      rxFull_r <= 1'b0;
    end else begin
      if (wrEn && idx == DCC_DATA) begin
        txFull_r <= 1'b1;
      end else if (dbgTxTaken) begin
        txFull_r <= 1'b0;
      end
      if (dbgRxValid && !rxFull_r) begin
        rxFull_r <= 1'b1;
      end else if (rdEn && idx == DCC_DATA) begin
        rxFull_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rdData = ZERO_WORD;
    if (idx == DCC_STATUS) begin
      rdData = {30'h0, rxFull_r, txFull_r};
    end else if (idx == DCC_DATA) begin
      rdData = rxData_r;
    end
  end
endmodule

// *** src/system_control_cop.sv ***
// Purpose: register bank of the system control coprocessor
// Assumes: core presents one transfer per copValid pulse, condition evaluated
// Notes: answers one cycle after the request
// What this block does
// - Decode four-bit index over sixteen locations
// - Secondary opcode picks among shared registers
// - Identification location writes are unpredictable
// - No access can wedge the device
// - Reset clears every state bit except the vector bit and the unreset vector pin synchroniser
// - Vector bit loads pin level at reset
// - Only privileged transfers reach system control registers; debug channel takes user transfers
// - Decode all transfer instruction fields
// - Debug channel coprocessor via same transfers
// - System control data ops, loads/stores, user transfers trap
// - Load bit: one reads, zero writes
`timescale 1ns/10ps
module system_control_cop
  import system_control_pkg::*;
#(
  // Arbitrary value, not a real maker code
  parameter logic [31:0] IDENT_WORD = 32'h1234_5670
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic highVectorInitIn,
  input wire logic copValid,
  input wire logic [31:0] copInstr,
  input wire logic condPass,
  input wire logic privileged,
  input wire logic [31:0] coreWriteData,
  output logic readValid,
  output logic [31:0] readData,
  output logic undefTrap,
  output logic [31:0] controlWord,
  output logic [31:0] cacheableData,
  output logic [31:0] cacheableInstr,
  output logic [31:0] writeBufWord,
  output logic [31:0] permitData,
  output logic [31:0] permitInstr,
  output logic [31:0] lockData,
  output logic [31:0] lockInstr,
  output logic [31:0] testWord,
  input wire logic [3:0] regionSel,
  output logic [31:0] regionWord,
  output logic cacheOpStrobe,
  output logic [31:0] cacheOpWord,
  output logic [6:0] cacheOpSel,
  input wire logic [31:0] dbgRxData,
  input wire logic dbgRxValid,
  output logic dbgRxReady,
  output logic [31:0] dbgTxData,
  output logic dbgTxValid,
  input wire logic dbgTxTaken
);
  import system_control_pkg::*;

  // ****************************************
  // Decode
  // ****************************************
  instr_class_t instrClass;
  logic readDir;
  logic [3:0] copNum;
  logic [3:0] primaryIdx;
  logic [3:0] auxIdx;
  logic [2:0] opc1;
  logic [2:0] opc2;

  cop_instr_decode u_decode (
    .instr(copInstr),
    .instrClass(instrClass),
    .readDir(readDir),
    .copNum(copNum),
    .primaryIdx(primaryIdx),
    .auxIdx(auxIdx),
    .opc1(opc1),
    .opc2(opc2),
    .coreReg()
  );

  // Only 0 and 1 name a real register in pair locations
  function automatic logic pairOk(input logic [2:0] sel);
    pairOk = (sel[2:1] == 2'b00);
  endfunction

  logic sysHit;
  logic xferHit;
  logic wrEn;
  logic rdEn;
  logic dbgHit;
  logic trapNxt;

  assign sysHit = copValid && condPass && copNum == CP_SYSCTL;
  assign xferHit = sysHit && instrClass == CLS_XFER;
  assign wrEn = xferHit && privileged && !readDir;
  assign rdEn = xferHit && privileged && readDir;
  assign dbgHit = copValid && condPass && copNum == CP_DEBUG && instrClass == CLS_XFER;
  assign trapNxt = sysHit && (instrClass == CLS_OTHER || !privileged);

  // ****************************************
  // Vector pin synchroniser
  // ****************************************
  // Reset must span three edges so the synced level is valid
  logic hviMeta_r;
  logic hviSync_r;
  always_ff @(posedge clock) begin
    hviMeta_r <= highVectorInitIn;
    hviSync_r <= hviMeta_r;
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] control_r;
  logic [31:0] writeBuf_r;
  logic [31:0] test_r;
  logic [31:0] cacheable_r [2];
  logic [31:0] permit_r [2];
  logic [31:0] lock_r [2];
  logic [31:0] region_r [2*REGIONS];

  // Clear all, vector bit from pin
  always_ff @(posedge clock) begin
    if (!rstn) begin
      control_r <= ZERO_WORD;
      control_r[CTRL_VECTOR_BIT] <= hviSync_r;
    end else if (wrEn && primaryIdx == REG_CONTROL) begin
      control_r <= coreWriteData;
    end
  end

  // Location 0 and reserved writes decode to nothing
  // Whole-word writes; opcode fields beyond selection ignored
  always_ff @(posedge clock) begin
    if (!rstn) begin
      writeBuf_r <= ZERO_WORD;
      test_r <= ZERO_WORD;
    end else begin
      if (wrEn && primaryIdx == REG_WRBUF) begin
        writeBuf_r <= coreWriteData;
      end
      if (wrEn && primaryIdx == REG_TEST) begin
        test_r <= coreWriteData;
      end
    end
  end

  // Secondary opcode picks data or instruction side
  genvar side;
  generate
    for (side = 0; side < 2; side++) begin : g_side
      always_ff @(posedge clock) begin
        if (!rstn) begin
          cacheable_r[side] <= ZERO_WORD;
          permit_r[side] <= ZERO_WORD;
          lock_r[side] <= ZERO_WORD;
        end else if (wrEn && pairOk(opc2) && opc2[0] == 1'(side)) begin
          if (primaryIdx == REG_CACHEABLE) begin
            cacheable_r[side] <= coreWriteData;
          end
          if (primaryIdx == REG_PERMIT) begin
            permit_r[side] <= coreWriteData;
          end
          if (primaryIdx == REG_LOCKDOWN) begin
            lock_r[side] <= coreWriteData;
          end
        end
      end
    end
  endgenerate

  // Region word picked by side and region number
  logic regionWr;
  logic [3:0] regionIdx;
  assign regionWr = wrEn && primaryIdx == REG_REGION && pairOk(opc2) && !auxIdx[3];
  assign regionIdx = {opc2[0], auxIdx[2:0]};
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < 2*REGIONS; i++) begin
        region_r[i] <= ZERO_WORD;
      end
    end else if (regionWr) begin
      region_r[regionIdx] <= coreWriteData;
    end
  end

  // Write-only location becomes a command pulse
  logic cacheOp_r;
  logic [31:0] cacheOpWord_r;
  logic [6:0] cacheOpSel_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cacheOp_r <= 1'b0;
      cacheOpWord_r <= ZERO_WORD;
      cacheOpSel_r <= 7'h00;
    end else begin
      cacheOp_r <= wrEn && primaryIdx == REG_CACHEOP;
      if (wrEn && primaryIdx == REG_CACHEOP) begin
        cacheOpWord_r <= coreWriteData;
        cacheOpSel_r <= {opc2, auxIdx};
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [31:0] dbgRdData;
  logic [31:0] readNxt;

  always_comb begin
    readNxt = ZERO_WORD;
    unique case (primaryIdx)
      REG_IDENT: begin
        // Cache geometry only on opcode 1
        readNxt = (opc2 == OPC2_CACHE_GEOM) ? CACHE_GEOM_WORD : IDENT_WORD;
      end
      REG_CONTROL: readNxt = control_r;
      REG_CACHEABLE: readNxt = pairOk(opc2) ? cacheable_r[opc2[0]] : ZERO_WORD;
      REG_WRBUF: readNxt = writeBuf_r;
      REG_PERMIT: readNxt = pairOk(opc2) ? permit_r[opc2[0]] : ZERO_WORD;
      REG_REGION: readNxt = (pairOk(opc2) && !auxIdx[3]) ? region_r[regionIdx] : ZERO_WORD;
      REG_LOCKDOWN: readNxt = pairOk(opc2) ? lock_r[opc2[0]] : ZERO_WORD;
      REG_TEST: readNxt = test_r;
      // Unpredictable and reserved read as zero
      default: readNxt = ZERO_WORD;
    endcase
  end

  logic readValid_r;
  logic [31:0] readData_r;
  logic trap_r;
  logic [31:0] regionWord_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      readValid_r <= 1'b0;
      readData_r <= ZERO_WORD;
      trap_r <= 1'b0;
      regionWord_r <= ZERO_WORD;
    end else begin
      readValid_r <= rdEn || (dbgHit && readDir);
      if (rdEn) begin
        readData_r <= readNxt;
      end else if (dbgHit && readDir) begin
        readData_r <= dbgRdData;
      end
      trap_r <= trapNxt;
      regionWord_r <= region_r[regionSel];
    end
  end

  debug_comms_cop u_dcc (
    .clock(clock),
    .rstn(rstn),
    .wrEn(dbgHit && !readDir),
    .rdEn(dbgHit && readDir),
    .idx(primaryIdx),
    .wrData(coreWriteData),
    .rdData(dbgRdData),
    .dbgRxData(dbgRxData),
    .dbgRxValid(dbgRxValid),
    .dbgRxReady(dbgRxReady),
    .dbgTxData(dbgTxData),
    .dbgTxValid(dbgTxValid),
    .dbgTxTaken(dbgTxTaken)
  );

  assign readValid = readValid_r;
  assign readData = readData_r;
  assign undefTrap = trap_r;
  assign controlWord = control_r;
  assign cacheableData = cacheable_r[0];
  assign cacheableInstr = cacheable_r[1];
  assign writeBufWord = writeBuf_r;
  assign permitData = permit_r[0];
  assign permitInstr = permit_r[1];
  assign lockData = lock_r[0];
  assign lockInstr = lock_r[1];
  assign testWord = test_r;
  assign regionWord = regionWord_r;
  assign cacheOpStrobe = cacheOp_r;
  assign cacheOpWord = cacheOpWord_r;
  assign cacheOpSel = cacheOpSel_r;

  // ****************************************
  // Assertions
  // ****************************************
  property p_reset_clear;
    @(posedge clock) !rstn |=> (controlWord & ~(32'h1 << CTRL_VECTOR_BIT)) == 32'h0
      && cacheableData == 32'h0 && lockInstr == 32'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state set");

  property p_reset_vector;
    // Synchroniser holds a valid level after the second reset edge; control loads it on the third
    @(posedge clock) !rstn ##1 !rstn ##1 !rstn
      |=> controlWord[CTRL_VECTOR_BIT] == $past(hviSync_r);
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("vector bit wrong");

  property p_user_blocked;
    @(posedge clock) disable iff (!rstn)
      xferHit && !privileged |=> undefTrap && !readValid && $stable(controlWord);
  endproperty
  a_user_blocked: assert property (p_user_blocked) else $error("user access got in");

  property p_other_trap;
    @(posedge clock) disable iff (!rstn)
      sysHit && instrClass == CLS_OTHER |=> undefTrap ##1 !undefTrap || $past(trapNxt);
  endproperty
  a_other_trap: assert property (p_other_trap) else $error("no trap on data op");

  property p_read_answer;
    @(posedge clock) disable iff (!rstn)
      rdEn |=> readValid && !undefTrap;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  property p_write_word;
    @(posedge clock) disable iff (!rstn)
      wrEn && primaryIdx == REG_CONTROL |=> controlWord == $past(coreWriteData) && !readValid;
  endproperty
  a_write_word: assert property (p_write_word) else $error("control write lost");

  property p_pair_select;
    @(posedge clock) disable iff (!rstn)
      wrEn && primaryIdx == REG_CACHEABLE && opc2 == 3'h1
      |=> cacheableInstr == $past(coreWriteData) && $stable(cacheableData);
  endproperty
  a_pair_select: assert property (p_pair_select) else $error("wrong pair member");

  property p_reserved_write;
    @(posedge clock) disable iff (!rstn)
      wrEn && (primaryIdx == 4'h4 || primaryIdx == 4'h8 || primaryIdx == 4'ha)
      |=> $stable(controlWord) && $stable(writeBufWord) && $stable(testWord) && !cacheOpStrobe;
  endproperty
  a_reserved_write: assert property (p_reserved_write) else $error("reserved write acted");

  property p_ident_read;
    @(posedge clock) disable iff (!rstn)
      rdEn && primaryIdx == REG_IDENT |=> readData == ($past(opc2) == OPC2_CACHE_GEOM ?
      CACHE_GEOM_WORD : IDENT_WORD);
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("ident read wrong");

  property p_dcc_write;
    @(posedge clock) disable iff (!rstn)
      dbgHit && !readDir && primaryIdx == DCC_DATA |=> dbgTxValid && dbgTxData == $past(coreWriteData);
  endproperty
  a_dcc_write: assert property (p_dcc_write) else $error("debug word lost");

  c_read: cover property (@(posedge clock) disable iff (!rstn) rdEn ##1 readValid);
  c_trap: cover property (@(posedge clock) disable iff (!rstn) undefTrap);
  c_cacheop: cover property (@(posedge clock) disable iff (!rstn) cacheOpStrobe);
endmodule

// *** testbench/core_issue_model.sv ***
// Purpose: core side model issuing coprocessor register transfers
// Assumes: one transfer per call, core has evaluated the condition
// Notes: released lines carry inverted values so stale data never passes
`timescale 1ns/10ps
module core_issue_model (
  input wire logic clock,
  output logic copValid,
  output logic [31:0] copInstr,
  output logic condPass,
  output logic privileged,
  output logic [31:0] coreWriteData
);
  import system_control_pkg::*;

  initial begin
    copValid = 1'h0;
    copInstr = 32'h0;
    condPass = 1'h0;
    privileged = 1'h0;
    coreWriteData = 32'h0;
  end

  function automatic logic [31:0] mk(input logic rd, input logic [3:0] primary_reg_index,
      input logic [2:0] opc2, input logic [3:0] auxiliary_reg_index, input logic [3:0] cp);
    return {4'he, GROUP_COPROC, 3'h0, rd, primary_reg_index, 4'h0, cp, opc2, 1'h1, auxiliary_reg_index};
  endfunction

  task automatic issue(input logic [31:0] instr, input logic [31:0] data,
      input logic priv, input logic cond);
    @(posedge clock);
    copValid <= 1'h1;
    copInstr <= instr;
    coreWriteData <= data;
    privileged <= priv;
    condPass <= cond;
    @(posedge clock);
    copValid <= 1'h0;
    copInstr <= ~instr;
    coreWriteData <= ~data;
    privileged <= ~priv;
    condPass <= ~cond;
  endtask
endmodule

// *** testbench/system_control_cop_tb.sv ***
// Purpose: self-checking bench of the system control coprocessor registers
// Assumes: answers just after the edge that takes the transfer
// Notes: unpredictable reads are checked against the zero the design chose
`timescale 1ns/10ps
module system_control_cop_tb;
  import system_control_pkg::*;
  // Arbitrary identification value
  localparam logic [31:0] IDENT = 32'h5a5a_0011;
  localparam logic [3:0] SLOT_LOC [9] = '{REG_CONTROL, REG_CACHEABLE, REG_CACHEABLE,
      REG_WRBUF, REG_PERMIT, REG_PERMIT, REG_LOCKDOWN, REG_LOCKDOWN, REG_TEST};
  localparam logic [2:0] SLOT_OPC [9] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0};
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic highVectorInitIn = 1'h1;
  logic copValid, condPass, privileged, readValid, undefTrap, cacheOpStrobe;
  logic dbgRxValid, dbgRxReady, dbgTxValid, dbgTxTaken;
  logic [31:0] copInstr, coreWriteData, readData, controlWord, cacheableData;
  logic [31:0] cacheableInstr, writeBufWord, permitData, permitInstr, lockData;
  logic [31:0] lockInstr, testWord, regionWord, cacheOpWord, dbgRxData, dbgTxData;
  logic [6:0] cacheOpSel;
  logic [3:0] regionSel;
  logic [31:0] expReg [9];
  logic [31:0] d, r;
  int s;
  int mismatches = 0;
  int checksDone = 0;
  wire logic [287:0] allSeen = {controlWord, cacheableData, cacheableInstr, writeBufWord,
      permitData, permitInstr, lockData, lockInstr, testWord};

  always #20 clock = ~clock;

  core_issue_model cm (.clock(clock), .copValid(copValid), .copInstr(copInstr),
    .condPass(condPass), .privileged(privileged), .coreWriteData(coreWriteData));

  system_control_cop #(.IDENT_WORD(IDENT)) dut (.clock(clock), .rstn(rstn),
    .highVectorInitIn(highVectorInitIn), .copValid(copValid), .copInstr(copInstr),
    .condPass(condPass), .privileged(privileged), .coreWriteData(coreWriteData),
    .readValid(readValid), .readData(readData), .undefTrap(undefTrap),
    .controlWord(controlWord), .cacheableData(cacheableData),
    .cacheableInstr(cacheableInstr), .writeBufWord(writeBufWord), .permitData(permitData),
    .permitInstr(permitInstr), .lockData(lockData), .lockInstr(lockInstr),
    .testWord(testWord), .regionSel(regionSel), .regionWord(regionWord),
    .cacheOpStrobe(cacheOpStrobe), .cacheOpWord(cacheOpWord), .cacheOpSel(cacheOpSel),
    .dbgRxData(dbgRxData), .dbgRxValid(dbgRxValid), .dbgRxReady(dbgRxReady),
    .dbgTxData(dbgTxData), .dbgTxValid(dbgTxValid), .dbgTxTaken(dbgTxTaken));

  function automatic logic [287:0] allExp();
    return {expReg[0], expReg[1], expReg[2], expReg[3], expReg[4], expReg[5], expReg[6],
        expReg[7], expReg[8]};
  endfunction

  task automatic chk(input logic [287:0] seen, input logic [287:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic [31:0] instr, input logic [31:0] data, input logic priv);
    cm.issue(instr, data, priv, 1'h1);
    #1;
  endtask

  task automatic resetChk(input logic pin);
    foreach (expReg[i]) expReg[i] = 32'h0;
    expReg[0][CTRL_VECTOR_BIT] = pin;
    chk(allSeen, allExp());
    chk({readValid, undefTrap, cacheOpStrobe, dbgTxValid, regionWord, dbgRxReady},
        37'h1);
  endtask

  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    results();
  end

  initial begin
    regionSel = 4'h0;
    dbgRxData = 32'h0;
    dbgRxValid = 1'h0;
    dbgTxTaken = 1'h0;
    void'($urandom(28));
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    #1;
    resetChk(1'h1);
    // Every stored register outside the region bank written then read back, test location included
    for (int n = 0; n < 20; n++) begin
      s = (n < 9) ? n : $urandom_range(8);
      d = $urandom;
      xfer(cm.mk(1'h0, SLOT_LOC[s], SLOT_OPC[s], 4'h0, CP_SYSCTL), d, 1'h1);
      expReg[s] = d;
      chk(allSeen, allExp());
      xfer(cm.mk(1'h1, SLOT_LOC[s], SLOT_OPC[s], 4'h0, CP_SYSCTL), ~d, 1'h1);
      chk({readValid, readData}, {1'h1, d});
    end
    for (int k = 0; k < 3; k++) begin
      xfer(cm.mk(1'h1, REG_IDENT, k[2:0], 4'h0, CP_SYSCTL), 32'h0, 1'h1);
      chk(readData, (k == 1) ? CACHE_GEOM_WORD : IDENT);
    end
    // Writes that must leave every register alone
    for (int k = 0; k < 15; k++) begin
      if (!(k inside {0, 4, 8, [10:14]})) continue;
      xfer(cm.mk(1'h0, k[3:0], 3'h0, 4'h0, CP_SYSCTL), $urandom, 1'h1);
      chk(allSeen, allExp());
      xfer(cm.mk(1'h1, k[3:0], 3'h0, 4'h0, CP_SYSCTL), 32'h0, 1'h1);
      if (k != 0) chk(readData, 32'h0);
    end
    xfer(cm.mk(1'h0, REG_CACHEABLE, 3'h3, 4'h0, CP_SYSCTL), $urandom, 1'h1);
    chk(allSeen, allExp());
    d = $urandom;
    xfer(cm.mk(1'h0, REG_CACHEOP, 3'h5, 4'ha, CP_SYSCTL), d, 1'h1);
    chk({cacheOpStrobe, cacheOpSel, cacheOpWord, allSeen}, {1'h1, 7'h5a, d, allExp()});
    @(posedge clock);
    #1;
    chk(cacheOpStrobe, 1'h0);
    for (int k = 0; k < 16; k += 5) begin
      d = $urandom;
      xfer(cm.mk(1'h0, REG_REGION, {2'h0, k[3]}, {1'h0, k[2:0]}, CP_SYSCTL), d, 1'h1);
      @(posedge clock);
      regionSel <= k[3:0];
      repeat (2) @(posedge clock);
      #1;
      chk(regionWord, d);
      xfer(cm.mk(1'h1, REG_REGION, {2'h0, k[3]}, {1'h0, k[2:0]}, CP_SYSCTL), 32'h0, 1'h1);
      chk(readData, d);
    end
    xfer(cm.mk(1'h0, REG_CONTROL, 3'h0, 4'h0, CP_SYSCTL), $urandom, 1'h0);
    chk({undefTrap, allSeen}, {1'h1, allExp()});
    xfer(cm.mk(1'h1, REG_CONTROL, 3'h0, 4'h0, CP_SYSCTL), 32'h0, 1'h0);
    chk({undefTrap, readValid}, 2'h2);
    xfer(cm.mk(1'h0, REG_CONTROL, 3'h0, 4'h0, CP_SYSCTL) & ~32'h10, $urandom, 1'h1);
    chk({undefTrap, allSeen}, {1'h1, allExp()});
    xfer({4'he, GROUP_LOADSTORE, 9'h0, 4'h0, CP_SYSCTL, 8'h0}, 32'h0, 1'h1);
    chk(undefTrap, 1'h1);
    cm.issue(cm.mk(1'h0, REG_CONTROL, 3'h0, 4'h0, CP_SYSCTL), $urandom, 1'h1, 1'h0);
    #1;
    chk({undefTrap, allSeen}, {1'h0, allExp()});
    d = $urandom;
    r = $urandom;
    xfer(cm.mk(1'h0, DCC_DATA, 3'h0, 4'h0, CP_DEBUG), d, 1'h0);
    chk({undefTrap, dbgTxValid, dbgTxData}, {1'h0, 1'h1, d});
    @(posedge clock);
    dbgRxValid <= 1'h1;
    dbgRxData <= r;
    @(posedge clock);
    dbgRxValid <= 1'h0;
    dbgRxData <= ~r;
    #1;
    chk(dbgRxReady, 1'h0);
    xfer(cm.mk(1'h1, DCC_STATUS, 3'h0, 4'h0, CP_DEBUG), 32'h0, 1'h1);
    chk(readData, 32'h3);
    @(posedge clock);
    dbgTxTaken <= 1'h1;
    @(posedge clock);
    dbgTxTaken <= 1'h0;
    #1;
    chk(dbgTxValid, 1'h0);
    xfer(cm.mk(1'h1, DCC_DATA, 3'h0, 4'h0, CP_DEBUG), 32'h0, 1'h1);
    chk({readValid, readData, dbgRxReady}, {1'h1, r, 1'h1});
    // Second reset in mid-run with the vector pin low
    @(posedge clock);
    rstn <= 1'h0;
    highVectorInitIn <= 1'h0;
    repeat (4) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    #1;
    resetChk(1'h0);
    d = $urandom;
    xfer(cm.mk(1'h0, REG_CONTROL, 3'h0, 4'h0, CP_SYSCTL), d, 1'h1);
    chk(controlWord, d);
    results();
  end
endmodule
